/* hdl/motor_pwm_channel_manager.sv */
// current-mode pwm, channel manager, emergency stop, flags and axi4-lite registers
// assumes event pulses and voltage pwm come from logic on aclk; pins are synchronised
//
// Overview of operation
// - current mode pwm combines measurement window with current comparator
// - optional filter masks comparator trips for 2.5 us after pwm switch-on
// - pwm on from window end until next window start or comparator trip
// - four-bit sampling ratio picks one of sixteen window frequencies
// - sensorless off-time field selects 5, 10, 15 or 30 us window
// - sensor mode forces 1.25 us window regardless of off-time field
// - window is offered for demag end or zero crossing detection
// - phase writes go to preload, copied to active on commutation
// - pin level from polarity and phase; phase zero means switch off
// - direct access makes phase writes reach active register at once
// - enable clear tristates outputs; timer runs only with enable and no direct
// - group bits place each channel in even or odd group
// - low select bits route pwm to groups between d and c events
// - top select bit drives demag pwm, preloaded at commutation
// - select decoding differs between voltage and current mode
// - voltage mode select 010 gives full-on outputs, no pwm or limit
// - emergency low tristates outputs, clears enable, raises its flag
// - emergency tristate path works with no clock running
// - wait mode keeps running; enabled events request wake-up
// - halt freezes motor control state except the emergency enable clear; own events cannot wake
// - events set flags; interrupt needs enable bit and cpu mask clear
// - eight-bit up timer, read-only while running
//
// Our own choices: the register addresses and the AXI4-Lite register port.
`timescale 1ns/10ps
module motor_pwm_channel_manager import motor_pwm_pkg::*; #(
  parameter int unsigned CLK_HZ = CLK_HZ_DEF
) (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [ADDR_W-1:0] awaddr,
  input wire logic awvalid,
  output logic awready,
  input wire logic [31:0] wdata,
  input wire logic [3:0] wstrb,
  input wire logic wvalid,
  output logic wready,
  output logic [1:0] bresp,
  output logic bvalid,
  input wire logic bready,
  input wire logic [ADDR_W-1:0] araddr,
  input wire logic arvalid,
  output logic arready,
  output logic [31:0] rdata,
  output logic [1:0] rresp,
  output logic rvalid,
  input wire logic rready,
  input wire logic emergency_stop_n,
  input wire logic current_feedback_in,
  input wire logic voltage_pwm_in,
  input wire logic commutation_evt,
  input wire logic demag_end_evt,
  input wire logic zero_cross_evt,
  input wire logic ratio_inc_evt,
  input wire logic ratio_dec_evt,
  input wire logic mult_ovf_evt,
  input wire logic demag_active,
  input wire logic halt_mode,
  input wire logic cpu_irq_mask,
  output logic [5:0] motor_outputs,
  output logic [5:0] motor_outputs_oe_n,
  output logic meas_window,
  output logic timer_clk_en,
  output logic mtc_irq,
  output logic wake_request
);

  localparam int unsigned FILT_CYC = ns_to_cyc(FILTER_NS, CLK_HZ);
  localparam int unsigned SENS_CYC = ns_to_cyc(SENSOR_OFF_NS, CLK_HZ);

  logic emg_s1_reg, emg_s2_reg, emg_s3_reg, cl_s1_reg, cl_s2_reg;
  logic aw_held_reg, w_held_reg, wstb_reg, bvalid_reg, rvalid_reg;
  logic [7:0] awaddr_reg, wdata_reg, rdata_reg;
  logic [1:0] bresp_reg, rresp_reg;
  logic oe_bit_reg, sensor_reg, dac_reg, vc_reg, filt_reg;
  logic [1:0] os_lo_reg, ot_reg;
  logic demag_pre_reg, demag_sel_reg;
  logic [3:0] sa_reg;
  logic [5:0] pol_reg, phase_pre_reg, phase_act_reg, parity_reg, mask_reg, motor_out_reg;
  logic [6:0] flags_reg;
  logic [7:0] timer_reg;
  logic [PER_W-1:0] win_cnt_reg;
  logic [CNT_W-1:0] blank_reg;
  logic meas_win_reg, pwm_cur_reg;
  logic [7:0] rd_val;
  logic [PER_W-1:0] per_tab [16];
  logic [PER_W-1:0] off_tab [4];

  // pin synchronisers
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      emg_s1_reg <= 1'b1;
      emg_s2_reg <= 1'b1;
      emg_s3_reg <= 1'b1;
      cl_s1_reg <= 1'b0;
      cl_s2_reg <= 1'b0;
    end else begin
      emg_s1_reg <= emergency_stop_n;
      emg_s2_reg <= emg_s1_reg;
      emg_s3_reg <= emg_s2_reg;
      cl_s1_reg <= current_feedback_in;
      cl_s2_reg <= cl_s1_reg;
    end
  end

  wire emg_fall = emg_s3_reg & ~emg_s2_reg;
  wire cl_trip = cl_s2_reg;
  wire run = ~halt_mode;

  // axi4-lite write channel
  assign awready = ~aw_held_reg & ~bvalid_reg;
  assign wready = ~w_held_reg & ~bvalid_reg;
  wire aw_take = awvalid & awready;
  wire w_take = wvalid & wready;
  wire wr_go = aw_held_reg & w_held_reg & ~bvalid_reg;
  wire wr_en = wr_go & wstb_reg;
  wire [7:0] wd = wdata_reg;
  wire wr_ctrl_a = wr_en & (awaddr_reg == OFF_CTRL_A);
  wire wr_ctrl_b = wr_en & (awaddr_reg == OFF_CTRL_B);
  wire wr_presc = wr_en & (awaddr_reg == OFF_PRESCALE);
  wire wr_pol = wr_en & (awaddr_reg == OFF_POLARITY);
  wire wr_phase = wr_en & (awaddr_reg == OFF_PHASE);
  wire wr_parity = wr_en & (awaddr_reg == OFF_PARITY);
  wire wr_mask = wr_en & (awaddr_reg == OFF_IRQ_MASK);
  wire wr_status = wr_en & (awaddr_reg == OFF_STATUS);
  wire wr_timer = wr_en & (awaddr_reg == OFF_TIMER);
  assign bvalid = bvalid_reg;
  assign bresp = bresp_reg;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_held_reg <= 1'b0;
      w_held_reg <= 1'b0;
      awaddr_reg <= RST_BYTE;
      wdata_reg <= RST_BYTE;
      wstb_reg <= 1'b0;
      bvalid_reg <= 1'b0;
      bresp_reg <= RESP_OKAY;
    end else begin
      if (aw_take) begin
        aw_held_reg <= 1'b1;
        awaddr_reg <= awaddr;
      end else if (wr_go) begin
        aw_held_reg <= 1'b0;
      end
      if (w_take) begin
        w_held_reg <= 1'b1;
        wdata_reg <= wdata[7:0];
        wstb_reg <= wstrb[0];
      end else if (wr_go) begin
        w_held_reg <= 1'b0;
      end
      if (wr_go) begin
        bvalid_reg <= 1'b1;
        bresp_reg <= reg_mapped(awaddr_reg) ? RESP_OKAY : RESP_SLVERR;
      end else if (bready) begin
        bvalid_reg <= 1'b0;
      end
    end
  end

  // axi4-lite read channel
  assign arready = ~rvalid_reg;
  assign rvalid = rvalid_reg;
  assign rresp = rresp_reg;
  assign rdata = {24'h000000, rdata_reg};

  always_comb begin
    rd_val = RST_BYTE;
    if (araddr == OFF_CTRL_A) begin
      rd_val = {oe_bit_reg, 1'b0, sensor_reg, dac_reg, vc_reg, 3'h0};
    end else if (araddr == OFF_CTRL_B) begin
      rd_val = {4'h0, demag_pre_reg, os_lo_reg, filt_reg};
    end else if (araddr == OFF_PRESCALE) begin
      rd_val = {sa_reg, 4'h0};
    end else if (araddr == OFF_POLARITY) begin
      rd_val = {ot_reg, pol_reg};
    end else if (araddr == OFF_PHASE) begin
      rd_val = {2'h0, phase_pre_reg};
    end else if (araddr == OFF_PARITY) begin
      rd_val = {2'h0, parity_reg};
    end else if (araddr == OFF_IRQ_MASK) begin
      rd_val = {1'b0, cl_trip, mask_reg};
    end else if (araddr == OFF_STATUS) begin
      rd_val = {1'b0, flags_reg};
    end else if (araddr == OFF_TIMER) begin
      rd_val = timer_reg;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rvalid_reg <= 1'b0;
      rdata_reg <= RST_BYTE;
      rresp_reg <= RESP_OKAY;
    end else if (arvalid && arready) begin
      rvalid_reg <= 1'b1;
      rdata_reg <= rd_val;
      rresp_reg <= reg_mapped(araddr) ? RESP_OKAY : RESP_SLVERR;
    end else if (rready) begin
      rvalid_reg <= 1'b0;
    end
  end

  // configuration and phase registers
  wire load_c = commutation_evt & run;
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      {oe_bit_reg, sensor_reg, dac_reg, vc_reg, filt_reg, demag_pre_reg} <= 6'h00;
      {demag_sel_reg, os_lo_reg, ot_reg, sa_reg} <= 9'h000;
      {pol_reg, phase_pre_reg, phase_act_reg} <= 18'h00000;
      {parity_reg, mask_reg} <= 12'h000;
    end else begin
      if (wr_ctrl_a) begin
        {oe_bit_reg, sensor_reg, dac_reg, vc_reg} <= {wd[CA_OE], wd[CA_SENSOR:CA_VC]};
      end
      if (emg_fall) begin
        oe_bit_reg <= 1'b0;
      end
      if (wr_ctrl_b) begin
        {demag_pre_reg, os_lo_reg, filt_reg} <= wd[CB_OS_HI:CB_FILT];
      end
      if (wr_presc) begin
        sa_reg <= wd[PS_SA_LO+:4];
      end
      if (wr_pol) begin
        {ot_reg, pol_reg} <= wd;
      end
      if (wr_phase) begin
        phase_pre_reg <= wd[5:0];
      end
      if (wr_phase && dac_reg) begin
        phase_act_reg <= wd[5:0];
      end else if (load_c) begin
        phase_act_reg <= phase_pre_reg;
      end
      if (wr_ctrl_b && dac_reg) begin
        demag_sel_reg <= wd[CB_OS_HI];
      end else if (load_c) begin
        demag_sel_reg <= demag_pre_reg;
      end
      if (wr_parity) begin
        parity_reg <= wd[5:0];
      end
      if (wr_mask) begin
        mask_reg <= wd[5:0];
      end
    end
  end

  // event flags, set wins over write-one-to-clear
  wire [6:0] ev = {ratio_inc_evt, ratio_dec_evt, mult_ovf_evt, emg_fall,
                   zero_cross_evt, demag_end_evt, commutation_evt} & {7{run}};
  wire [6:0] clr = wr_status ? wd[6:0] : 7'h00;
  wire [6:0] flags_next = (flags_reg & ~clr) | ev;
  wire [6:0] en7 = {mask_reg[FL_RDEC], mask_reg};
  wire pend = |(flags_reg & en7);
  assign mtc_irq = pend & ~cpu_irq_mask;
  assign wake_request = pend;

  // motor timer, clock gated by enable and direct access
  wire clk_on = oe_bit_reg & ~dac_reg;
  assign timer_clk_en = clk_on & run;
  wire [7:0] timer_next = timer_clk_en ? timer_reg + 8'h01 :
                          ((wr_timer && !clk_on) ? wd : timer_reg);

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      flags_reg <= 7'h00;
      timer_reg <= RST_BYTE;
    end else begin
      flags_reg <= flags_next;
      timer_reg <= timer_next;
    end
  end

  // measurement window and filter tables
  genvar gi;
  generate
    for (gi = 0; gi < 16; gi++) begin : g_per
      assign per_tab[gi] = PER_W'(period_cyc(SAMPLE_CHZ[gi], CLK_HZ));
    end
    for (gi = 0; gi < 4; gi++) begin : g_off
      assign off_tab[gi] = PER_W'(ns_to_cyc(OFF_TIME_NS[gi], CLK_HZ));
    end
  endgenerate

  wire [PER_W-1:0] per_cyc = per_tab[sa_reg];
  wire [PER_W-1:0] off_cyc = sensor_reg ? PER_W'(SENS_CYC) : off_tab[ot_reg];
  wire win_wrap = win_cnt_reg >= per_cyc - PER_W'(1);
  wire [PER_W-1:0] win_cnt_next = !run ? win_cnt_reg :
                                  (win_wrap ? '0 : win_cnt_reg + PER_W'(1));
  wire meas_win_next = run ? (win_cnt_next < off_cyc) : meas_win_reg;
  wire blanked = filt_reg & (blank_reg < CNT_W'(FILT_CYC));
  wire trip = cl_trip & ~blanked;
  // on from window end to next window start or comparator trip
  wire pwm_cur_next = run ? (~meas_win_next & (meas_win_reg | pwm_cur_reg) & ~trip)
                          : pwm_cur_reg;
  wire [CNT_W-1:0] blank_next = (!run || !blanked) ? blank_reg :
                                blank_reg + CNT_W'(1);
  assign meas_window = meas_win_reg;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      win_cnt_reg <= '0;
      meas_win_reg <= 1'b0;
      pwm_cur_reg <= 1'b0;
      blank_reg <= '0;
    end else begin
      win_cnt_reg <= win_cnt_next;
      meas_win_reg <= meas_win_next;
      pwm_cur_reg <= pwm_cur_next;
      blank_reg <= meas_win_reg ? '0 : blank_next;
    end
  end

  // channel manager
  wire pwm_src = vc_reg ? pwm_cur_reg : (voltage_pwm_in & ~cl_trip);
  wire [1:0] grp = pwm_groups(vc_reg, demag_active & ~sensor_reg,
                              demag_sel_reg, os_lo_reg);
  logic [5:0] out_next;
  generate
    for (gi = 0; gi < 6; gi++) begin : g_ch
      wire in_grp = parity_reg[gi] ? grp[1] : grp[0];
      wire on = phase_act_reg[gi] & (~in_grp | pwm_src);
      assign out_next[gi] = ~(on ^ pol_reg[gi]);
    end
  endgenerate

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      motor_out_reg <= 6'h00;
    end else if (run) begin
      motor_out_reg <= out_next;
    end
  end

  assign motor_outputs = motor_out_reg;
  // clockless release straight from the pin
  assign motor_outputs_oe_n = {6{~(oe_bit_reg & emergency_stop_n)}};

  chk_phase_load: assert property (@(posedge aclk) disable iff (!aresetn)
    commutation_evt && run && !dac_reg |=> phase_act_reg == $past(phase_pre_reg))
    else $error("phase preload not copied on commutation");
  chk_emerg_hiz: assert property (@(posedge aclk) disable iff (!aresetn)
    !emergency_stop_n |-> &motor_outputs_oe_n)
    else $error("outputs driven while emergency low");
  chk_emerg_moe: assert property (@(posedge aclk) disable iff (!aresetn)
    $fell(emg_s2_reg) |=> !oe_bit_reg && flags_reg[FL_EMERG])
    else $error("emergency did not clear enable or set flag");
  chk_flag_comm: assert property (@(posedge aclk) disable iff (!aresetn)
    commutation_evt && run |=> flags_reg[FL_COMM])
    else $error("commutation flag lost");
  chk_irq_gate: assert property (@(posedge aclk) disable iff (!aresetn)
    flags_reg[FL_COMM] && mask_reg[FL_COMM] |-> mtc_irq == !cpu_irq_mask)
    else $error("interrupt gating wrong");
  chk_timer_stop: assert property (@(posedge aclk) disable iff (!aresetn)
    !(oe_bit_reg && !dac_reg) && !wr_timer |=> $stable(timer_reg))
    else $error("timer moved while stopped");
  chk_off_level: assert property (@(posedge aclk) disable iff (!aresetn)
    !phase_act_reg[0] && run |=> motor_out_reg[0] == !$past(pol_reg[0]))
    else $error("off level wrong for polarity");
  chk_win_pwm: assert property (@(posedge aclk) disable iff (!aresetn)
    meas_win_reg |-> !pwm_cur_reg)
    else $error("pwm on inside measurement window");
  chk_halt_hold: assert property (@(posedge aclk) disable iff (!aresetn)
    halt_mode |=> $stable(win_cnt_reg) && $stable(motor_out_reg) && $stable(pwm_cur_reg))
    else $error("state moved during halt");

endmodule // motor_pwm_channel_manager

/* hdl/motor_pwm_pkg.sv */
// constants, register map and decode helpers for the motor pwm channel manager
// assumes a single clock domain and an axi4-lite register bus with 8-bit offsets
package motor_pwm_pkg;

  localparam int unsigned CLK_HZ_DEF = 250_000_000;
  localparam int ADDR_W = 8;
  localparam int PER_W = 24;
  localparam int CNT_W = 16;

  // register byte offsets
  localparam logic [7:0] OFF_CTRL_A = 8'h00;
  localparam logic [7:0] OFF_CTRL_B = 8'h04;
  localparam logic [7:0] OFF_PRESCALE = 8'h08;
  localparam logic [7:0] OFF_POLARITY = 8'h0c;
  localparam logic [7:0] OFF_PHASE = 8'h10;
  localparam logic [7:0] OFF_PARITY = 8'h14;
  localparam logic [7:0] OFF_IRQ_MASK = 8'h18;
  localparam logic [7:0] OFF_STATUS = 8'h1c;
  localparam logic [7:0] OFF_TIMER = 8'h20;

  // field positions
  localparam int CA_OE = 7;
  localparam int CA_SENSOR = 5;
  localparam int CA_DAC = 4;
  localparam int CA_VC = 3;
  localparam int CB_FILT = 0;
  localparam int CB_OS_LO = 1;
  localparam int CB_OS_HI = 3;
  localparam int PS_SA_LO = 4;
  localparam int PO_OT_LO = 6;
  localparam int IM_CL = 6;

  // flag positions in status, mask bits share the low six
  localparam int FL_COMM = 0;
  localparam int FL_DEMAG = 1;
  localparam int FL_ZERO = 2;
  localparam int FL_EMERG = 3;
  localparam int FL_OVF = 4;
  localparam int FL_RDEC = 5;
  localparam int FL_RINC = 6;

  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  localparam logic [7:0] RST_BYTE = 8'h00;

  // pwm group select, {odd, even}
  localparam logic [1:0] GRP_NONE = 2'h0;
  localparam logic [1:0] GRP_EVEN = 2'h1;
  localparam logic [1:0] GRP_ODD = 2'h2;
  localparam logic [1:0] GRP_BOTH = 2'h3;
  localparam logic [1:0] OS_FULL_ON = 2'h2;

  // times in ns, frequencies in hundredths of hz
  localparam int unsigned OFF_TIME_NS [4] = '{5000, 10000, 15000, 30000};
  localparam int unsigned SENSOR_OFF_NS = 1250;
  localparam int unsigned FILTER_NS = 2500;
  localparam int unsigned SAMPLE_CHZ [16] = '{2500000, 2000000, 1810000, 1540000,
    1250000, 1000000, 625000, 313000, 156000, 125000, 114000, 96100, 78100, 62500,
    39000, 19500};

  // least time to cycles, rounded up, never below one
  function automatic int unsigned ns_to_cyc(input int unsigned ns, input int unsigned hz);
    longint unsigned c;
    c = (longint'(ns) * longint'(hz) + 64'd999999999) / 64'd1000000000;
    return (c == 64'd0) ? 1 : int'(c);
  endfunction

  function automatic int unsigned period_cyc(input int unsigned chz, input int unsigned hz);
    return int'((longint'(hz) * 64'd100) / longint'(chz));
  endfunction

  function automatic logic reg_mapped(input logic [7:0] a);
    return (a <= OFF_TIMER) && (a[1:0] == 2'h0);
  endfunction

  // which groups receive the pwm, meaning depends on voltage or current mode
  function automatic logic [1:0] pwm_groups(input logic cur, input logic demag,
                                            input logic dbit, input logic [1:0] sel);
    logic [1:0] g;
    g = GRP_NONE;
    if (!cur && !dbit && sel == OS_FULL_ON) begin
      g = GRP_NONE;
    end else if (demag) begin
      g = (dbit ^ cur) ? GRP_ODD : GRP_EVEN;
    end else if (cur) begin
      g = sel[1] ? GRP_BOTH : (sel[0] ? GRP_EVEN : GRP_ODD);
    end else begin
      g = (sel == 2'h0) ? GRP_EVEN : ((sel == 2'h1) ? GRP_ODD : GRP_BOTH);
    end
    return g;
  endfunction

endpackage

/* tb/bridge_model.sv */
// stand-in for the power bridge drivers on the six motor channels
// assumes the bench commands a driver fault and a current trip on aclk
`timescale 1ns/10ps
module bridge_model (
  input wire logic aclk,
  input wire logic [5:0] motor_outputs,
  input wire logic [5:0] motor_outputs_oe_n,
  input wire logic fault_cmd,
  input wire logic trip_cmd,
  output logic emergency_stop_n,
  output logic current_feedback_in,
  output logic [5:0] gate_level
);
  logic toggle_reg = 1'b0;
  always @(posedge aclk) toggle_reg <= !toggle_reg;
  // fault alarm pulls the stop line low
  assign emergency_stop_n = !fault_cmd;
  // comparator high once the current limit is reached
  assign current_feedback_in = trip_cmd;
  // released gates show a changing level
  assign gate_level = (motor_outputs & ~motor_outputs_oe_n) |
                      ({6{toggle_reg}} & motor_outputs_oe_n);
endmodule // bridge_model

/* tb/tb_top.sv */
// bench for the motor pwm channel manager: bus, channels, window, emergency
// assumes the design scaled to 25 MHz so window counts stay short
`timescale 1ns/10ps
module tb_top;
  import motor_pwm_pkg::*;
  localparam int OFF_CYC [4] = '{125, 250, 375, 750};
  localparam int SENS_CYC = 32;
  localparam int PER0 = 1000;
  localparam int PER1 = 1250;
  logic aclk = 1'b0;
  logic aresetn = 1'b0;
  logic [7:0] awaddr = 8'h00;
  logic [7:0] araddr = 8'h00;
  logic [31:0] wdata = 32'h0;
  logic awvalid = 1'b0;
  logic wvalid = 1'b0;
  logic arvalid = 1'b0;
  logic [6:0] evt_vec = 7'h00;
  logic halt_mode = 1'b0;
  logic demag_active = 1'b0;
  logic cpu_irq_mask = 1'b0;
  logic fault_cmd = 1'b0;
  logic trip_cmd = 1'b0;
  logic awready, wready, bvalid, arready, rvalid, emergency_stop_n, current_feedback_in;
  logic meas_window, timer_clk_en, mtc_irq, wake_request;
  logic [1:0] bresp, rresp;
  logic [31:0] rdata;
  logic [5:0] motor_outputs, motor_outputs_oe_n;
  int err_total = 0;
  int n_tests = 0;
  always #2 aclk = !aclk;
  motor_pwm_channel_manager #(.CLK_HZ(25_000_000)) u_dut (
    .aclk(aclk), .aresetn(aresetn), .awaddr(awaddr), .awvalid(awvalid), .awready(awready),
    .wdata(wdata), .wstrb(4'hf), .wvalid(wvalid), .wready(wready), .bresp(bresp),
    .bvalid(bvalid), .bready(1'b1), .araddr(araddr), .arvalid(arvalid), .arready(arready),
    .rdata(rdata), .rresp(rresp), .rvalid(rvalid), .rready(1'b1),
    .emergency_stop_n(emergency_stop_n), .current_feedback_in(current_feedback_in),
    .voltage_pwm_in(1'b0), .commutation_evt(evt_vec[0]), .demag_end_evt(evt_vec[1]),
    .zero_cross_evt(evt_vec[2]), .mult_ovf_evt(evt_vec[4]), .ratio_dec_evt(evt_vec[5]),
    .ratio_inc_evt(evt_vec[6]), .demag_active(demag_active), .halt_mode(halt_mode),
    .cpu_irq_mask(cpu_irq_mask), .motor_outputs(motor_outputs),
    .motor_outputs_oe_n(motor_outputs_oe_n), .meas_window(meas_window),
    .timer_clk_en(timer_clk_en), .mtc_irq(mtc_irq), .wake_request(wake_request));
  bridge_model u_bridge (
    .aclk(aclk), .motor_outputs(motor_outputs), .motor_outputs_oe_n(motor_outputs_oe_n),
    .fault_cmd(fault_cmd), .trip_cmd(trip_cmd), .emergency_stop_n(emergency_stop_n),
    .current_feedback_in(current_feedback_in), .gate_level());

  task automatic complete_run();
    $display("comparisons %0d mismatches %0d", n_tests, err_total);
    if (err_total == 0 && n_tests > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask
  task automatic timeout();
    err_total++;
    complete_run();
  endtask
  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    n_tests++;
    if (got !== exp) begin
      err_total++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic gap(input int n);
    repeat (n) @(posedge aclk);
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d, input logic [1:0] er);
    int k;
    logic aw_hit, w_hit, done;
    awaddr <= a;
    wdata <= {24'h0, d};
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    done = 1'b0;
    for (k = 0; k < 50 && !done; k++) begin
      @(negedge aclk);
      aw_hit = awvalid && awready;
      w_hit = wvalid && wready;
      done = bvalid === 1'b1;
      if (done) chk("bresp", {30'h0, er}, {30'h0, bresp});
      @(posedge aclk);
      if (aw_hit) awvalid <= 1'b0;
      if (w_hit) wvalid <= 1'b0;
    end
    if (!done) timeout();
  endtask
  task automatic rd_chk(input string what, input logic [7:0] a, input logic [31:0] m,
                        input logic [31:0] exp, input logic [1:0] er);
    int k;
    logic hit, done;
    araddr <= a;
    arvalid <= 1'b1;
    done = 1'b0;
    for (k = 0; k < 50 && !done; k++) begin
      @(negedge aclk);
      hit = arvalid && arready;
      done = rvalid === 1'b1;
      if (done) chk(what, exp, rdata & m);
      if (done) chk("rresp", {30'h0, er}, {30'h0, rresp});
      @(posedge aclk);
      if (hit) arvalid <= 1'b0;
    end
    if (!done) timeout();
  endtask
  task automatic pins(input string what, input logic [5:0] eo, input logic [5:0] eoe);
    @(negedge aclk);
    chk(what, {26'h0, eo}, {26'h0, motor_outputs});
    chk("oe_n", {26'h0, eoe}, {26'h0, motor_outputs_oe_n});
    @(posedge aclk);
  endtask
  task automatic pulse(input logic [6:0] v);
    evt_vec <= v;
    @(posedge aclk);
    evt_vec <= 7'h00;
    @(posedge aclk);
  endtask
  task automatic cnt_until(input logic lvl, inout int n);
    while (meas_window !== lvl) begin
      @(negedge aclk);
      n++;
      if (n > 20000) timeout();
    end
  endtask
  task automatic win_to(input logic lvl);
    int n;
    n = 0;
    @(negedge aclk);
    cnt_until(lvl, n);
    @(posedge aclk);
  endtask
  task automatic win_meas(output int w, output int p);
    int n;
    n = 0;
    @(negedge aclk);
    repeat (2) begin
      cnt_until(1'b0, n);
      cnt_until(1'b1, n);
    end
    n = 0;
    cnt_until(1'b0, n);
    w = n;
    cnt_until(1'b1, n);
    p = n;
    @(posedge aclk);
  endtask

  task automatic s_reset();
    rd_chk("timer", OFF_TIMER, 32'hff, 32'h0, RESP_OKAY);
    rd_chk("unmapped", 8'h24, 32'hffffffff, 32'h0, RESP_SLVERR);
    wr(8'h24, 8'hff, RESP_SLVERR);
    pins("reset pins", 6'h3f, 6'h3f);
  endtask
  task automatic s_phase();
    wr(OFF_CTRL_B, 8'h04, RESP_OKAY);
    wr(OFF_POLARITY, 8'h0f, RESP_OKAY);
    wr(OFF_PHASE, 8'h15, RESP_OKAY);
    wr(OFF_CTRL_A, 8'h80, RESP_OKAY);
    gap(2);
    pins("preload held", 6'h30, 6'h00);
    chk("timer run", 32'h1, {31'h0, timer_clk_en});
    pulse(7'h01);
    gap(2);
    pins("phase out", 6'h25, 6'h00);
    rd_chk("preload", OFF_PHASE, 32'h3f, 32'h15, RESP_OKAY);
  endtask
  task automatic s_flags();
    int i;
    wr(OFF_IRQ_MASK, 8'h3f, RESP_OKAY);
    wr(OFF_STATUS, 8'h7f, RESP_OKAY);
    for (i = 0; i < 7; i++) begin
      if (i != FL_EMERG) begin
        pulse(7'(1 << i));
        rd_chk("flag", OFF_STATUS, 32'h7f, 32'(1 << i), RESP_OKAY);
        @(negedge aclk);
        chk("irq", 32'h1, {31'h0, mtc_irq});
        @(posedge aclk);
        cpu_irq_mask <= 1'b1;
        @(negedge aclk);
        chk("irq masked", 32'h0, {31'h0, mtc_irq});
        chk("wake", 32'h1, {31'h0, wake_request});
        @(posedge aclk);
        cpu_irq_mask <= 1'b0;
        wr(OFF_STATUS, 8'(1 << i), RESP_OKAY);
      end
    end
    wr(OFF_IRQ_MASK, 8'h00, RESP_OKAY);
    pulse(7'h01);
    gap(1);
    chk("irq off", 32'h0, {30'h0, mtc_irq, wake_request});
    wr(OFF_STATUS, 8'h7f, RESP_OKAY);
  endtask
  task automatic s_direct();
    wr(OFF_CTRL_A, 8'h90, RESP_OKAY);
    wr(OFF_PHASE, 8'h3f, RESP_OKAY);
    gap(2);
    pins("direct", 6'h0f, 6'h00);
    chk("timer stop", 32'h0, {31'h0, timer_clk_en});
  endtask
  task automatic s_emerg();
    wr(OFF_IRQ_MASK, 8'h08, RESP_OKAY);
    fault_cmd <= 1'b1;
    @(negedge aclk);
    chk("oe async", 32'h3f, {26'h0, motor_outputs_oe_n});
    @(posedge aclk);
    gap(4);
    rd_chk("enable cleared", OFF_CTRL_A, 32'h80, 32'h0, RESP_OKAY);
    rd_chk("emerg flag", OFF_STATUS, 32'h08, 32'h08, RESP_OKAY);
    chk("emerg irq", 32'h1, {31'h0, mtc_irq});
    fault_cmd <= 1'b0;
    gap(4);
    chk("still off", 32'h3f, {26'h0, motor_outputs_oe_n});
    wr(OFF_CTRL_A, 8'h80, RESP_OKAY);
    gap(1);
    chk("re-enabled", 32'h0, {26'h0, motor_outputs_oe_n});
    wr(OFF_STATUS, 8'h08, RESP_OKAY);
  endtask
  task automatic s_window();
    int i, w, p;
    wr(OFF_CTRL_A, 8'h88, RESP_OKAY);
    for (i = 0; i < 4; i++) begin
      wr(OFF_POLARITY, 8'(i << 6), RESP_OKAY);
      win_meas(w, p);
      chk("off time", OFF_CYC[i], w);
    end
    chk("period 0", PER0, p);
    wr(OFF_PRESCALE, 8'h10, RESP_OKAY);
    win_meas(w, p);
    chk("period 1", PER1, p);
    wr(OFF_CTRL_A, 8'ha8, RESP_OKAY);
    win_meas(w, p);
    chk("sensor off", SENS_CYC, w);
  endtask
  task automatic s_pwm();
    int w, p;
    wr(OFF_CTRL_A, 8'h88, RESP_OKAY);
    wr(OFF_PRESCALE, 8'h00, RESP_OKAY);
    wr(OFF_POLARITY, 8'h00, RESP_OKAY);
    win_meas(w, p);
    gap(20);
    pins("in window", 6'h3f, 6'h00);
    win_to(1'b0);
    gap(5);
    pins("pwm on", 6'h00, 6'h00);
    trip_cmd <= 1'b1;
    gap(6);
    pins("trip off", 6'h3f, 6'h00);
    wr(OFF_CTRL_B, 8'h05, RESP_OKAY);
    win_to(1'b1);
    win_to(1'b0);
    gap(10);
    pins("filtered", 6'h00, 6'h00);
    gap(60);
    pins("filter over", 6'h3f, 6'h00);
    wr(OFF_PARITY, 8'h2a, RESP_OKAY);
    wr(OFF_CTRL_B, 8'h00, RESP_OKAY);
    gap(6);
    pins("odd group", 6'h2a, 6'h00);
    wr(OFF_CTRL_B, 8'h02, RESP_OKAY);
    gap(6);
    pins("even group", 6'h15, 6'h00);
    wr(OFF_CTRL_B, 8'h0a, RESP_OKAY);
    demag_active <= 1'b1;
    gap(6);
    pins("demag before c", 6'h2a, 6'h00);
    pulse(7'h01);
    gap(2);
    pins("demag after c", 6'h15, 6'h00);
    demag_active <= 1'b0;
    wr(OFF_STATUS, 8'h01, RESP_OKAY);
    wr(OFF_CTRL_A, 8'h80, RESP_OKAY);
    wr(OFF_CTRL_B, 8'h00, RESP_OKAY);
    gap(6);
    pins("voltage even", 6'h15, 6'h00);
    trip_cmd <= 1'b0;
  endtask
  task automatic s_halt();
    wr(OFF_CTRL_A, 8'h00, RESP_OKAY);
    halt_mode <= 1'b1;
    gap(1);
    pulse(7'h77);
    halt_mode <= 1'b0;
    rd_chk("halt flags", OFF_STATUS, 32'h7f, 32'h0, RESP_OKAY);
  endtask

  initial begin
    gap(2);
    aresetn <= 1'b1;
    gap(1);
    s_reset();
    s_phase();
    s_flags();
    s_direct();
    s_emerg();
    s_window();
    s_pwm();
    s_halt();
    complete_run();
  end
endmodule // tb_top
